/* File: design/rrx_exec.sv */
/*
 rrx_exec: executes the return-from-interrupt, return-literal,
 return-from-subroutine and rotate-left-through-carry instructions.
 Assumes a fetch unit offering one word at Q1, a return stack showing its
 top on stack_top and popping on stack_pop, and a register file on the
 same clock answering file_req.addr combinationally on file_rd_data.
*/
// What this block does
// - interrupt return pops stack into pc and sets high or low global enable.
// - interrupt return with fast bit 1 restores working, status, bank from shadows.
// - return-literal loads literal into working register and pops stack into pc.
// - return-literal pops and writes working register in Q4, then one idle cycle.
// - subroutine return pops stack and loads the popped top into pc.
// - subroutine return restores shadows only when fast bit is 1.
// - rotate shifts byte left, bit 7 into carry, old carry into bit 0.
// - rotate result goes to working register when dest is 0, else to file.
// - access bit 0 uses access bank; access bit 1 uses bank select register.
`timescale 1ns/10ps
`default_nettype none
module rrx_exec #(
   parameter int PC_W = rrx_pkg::PC_W_DEF
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic instr_valid,
   input wire logic [rrx_pkg::INSTR_W-1:0] instr,
   output logic instr_ready,
   input wire logic [PC_W-1:0] stack_top,
   output logic stack_pop,
   input wire logic int_level_high,
   input wire logic int_taken,
   input wire rrx_pkg::rrx_core_t shadow,
   input wire logic [rrx_pkg::DATA_W-1:0] file_rd_data,
   output rrx_pkg::rrx_file_req_t file_req,
   output rrx_pkg::rrx_core_t core,
   output logic [PC_W-1:0] pc,
   output logic high_prio_global_int_enable,
   output logic low_prio_global_int_enable
);
   if (PC_W < 2 || PC_W > 32) begin : g_chk
      $error("rrx_exec: PC_W must lie between 2 and 32");
   end

   rrx_pkg::rrx_qphase_t q_q, q_d;
   rrx_pkg::rrx_state_t state_q, state_d;
   rrx_pkg::rrx_core_t core_q, core_d;
   rrx_pkg::rrx_file_req_t file_req_q;
   logic active_q, active_d;
   logic [rrx_pkg::INSTR_W-1:0] instr_q;
   logic [PC_W-1:0] pc_q;
   logic pop_q;
   logic hi_en_q, lo_en_q;
   logic [rrx_pkg::DATA_W-1:0] rot_res_q;
   logic rot_c_q, rot_n_q, rot_z_q;

   // phase and decode wires
   logic at_q1, at_q2, at_q3, at_q4, exec_q4;
   logic is_ret_int, is_ret_sub, is_ret_lit, is_rot, is_ret, fast, dest_file;
   logic [rrx_pkg::BANK_W-1:0] bank_sel;
   logic [rrx_pkg::DATA_W-1:0] rot_dout;
   logic rot_cout, rot_neg, rot_zero;

   assign at_q1 = (q_q == rrx_pkg::QP_1);
   assign at_q2 = (q_q == rrx_pkg::QP_2);
   assign at_q3 = (q_q == rrx_pkg::QP_3);
   assign at_q4 = (q_q == rrx_pkg::QP_4);
   assign exec_q4 = active_q && at_q4;

   assign is_ret_int = (instr_q[15:1] == rrx_pkg::OP_RET_INT_HI);
   assign is_ret_sub = (instr_q[15:1] == rrx_pkg::OP_RET_SUB_HI);
   assign is_ret_lit = (instr_q[15:8] == rrx_pkg::OP_RET_LIT);
   assign is_rot = (instr_q[15:10] == rrx_pkg::OP_ROT_LC);
   assign is_ret = is_ret_int || is_ret_sub || is_ret_lit;
   assign fast = (is_ret_int || is_ret_sub) && instr_q[rrx_pkg::FLD_FAST];
   assign dest_file = instr_q[rrx_pkg::FLD_DEST];

   // access bank splits at the operand's top bit, bank select ignored
   assign bank_sel = instr_q[rrx_pkg::FLD_ACCESS] ? core_q.bank :
      (instr_q[rrx_pkg::FLD_SPLIT] ? rrx_pkg::ACC_BANK_HI : rrx_pkg::ACC_BANK_LO);

   // new word only taken at Q1 of a cycle that is not the idle one
   assign instr_ready = at_q1 && (state_q == rrx_pkg::ST_EXEC);
   assign active_d = at_q1 ? (instr_ready && instr_valid) : (at_q4 ? 1'b0 : active_q);

   rrx_rotate u_rot (
      .din(file_rd_data),
      .cin(core_q.status[rrx_pkg::ST_C]),
      .dout(rot_dout),
      .cout(rot_cout),
      .neg(rot_neg),
      .zero(rot_zero)
   );

   always_comb begin
      case (q_q)
         rrx_pkg::QP_1: q_d = rrx_pkg::QP_2;
         rrx_pkg::QP_2: q_d = rrx_pkg::QP_3;
         rrx_pkg::QP_3: q_d = rrx_pkg::QP_4;
         default: q_d = rrx_pkg::QP_1;
      endcase
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         rrx_pkg::ST_EXEC: begin
            if (exec_q4 && is_ret) begin
               state_d = rrx_pkg::ST_IDLE;
            end
         end
         rrx_pkg::ST_IDLE: begin
            if (at_q4) begin
               state_d = rrx_pkg::ST_EXEC;
            end
         end
         default: state_d = rrx_pkg::ST_EXEC;
      endcase
   end

   // shadow restore first, explicit writes after it
   always_comb begin
      core_d = core_q;
      if (exec_q4) begin
         if (fast) begin
            core_d = shadow;
         end
         if (is_ret_lit) begin
            core_d.w = instr_q[rrx_pkg::DATA_W-1:0];
         end
         if (is_rot) begin
            if (!dest_file) begin
               core_d.w = rot_res_q;
            end
            core_d.status[rrx_pkg::ST_C] = rot_c_q;
            core_d.status[rrx_pkg::ST_N] = rot_n_q;
            core_d.status[rrx_pkg::ST_Z] = rot_z_q;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q_q <= rrx_pkg::QP_1;
         state_q <= rrx_pkg::ST_EXEC;
         active_q <= 1'b0;
         instr_q <= '0;
         core_q <= {rrx_pkg::RST_W, rrx_pkg::RST_STATUS, rrx_pkg::RST_BANK};
      end else begin
         q_q <= q_d;
         state_q <= state_d;
         active_q <= active_d;
         if (instr_ready && instr_valid) begin
            instr_q <= instr;
         end
         core_q <= core_d;
      end
   end

   // pc latches upper and high are not touched here at all
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pc_q <= '0;
         pop_q <= 1'b0;
      end else begin
         pop_q <= active_q && at_q3 && is_ret;
         if (exec_q4 && is_ret) begin
            pc_q <= stack_top;
         end
      end
   end

   // interrupt entry clears, a return in the same cycle wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hi_en_q <= rrx_pkg::RST_INT_EN;
         lo_en_q <= rrx_pkg::RST_INT_EN;
      end else begin
         if (exec_q4 && is_ret_int && int_level_high) begin
            hi_en_q <= 1'b1;
         end else if (int_taken && int_level_high) begin
            hi_en_q <= 1'b0;
         end
         if (exec_q4 && is_ret_int && !int_level_high) begin
            lo_en_q <= 1'b1;
         end else if (int_taken && !int_level_high) begin
            lo_en_q <= 1'b0;
         end
      end
   end

   // address in Q2, operand sampled in Q3, write strobe stands through Q4
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         file_req_q <= '0;
         rot_res_q <= '0;
         rot_c_q <= 1'b0;
         rot_n_q <= 1'b0;
         rot_z_q <= 1'b0;
      end else begin
         if (active_q && at_q2 && is_rot) begin
            file_req_q.addr <= {bank_sel, instr_q[rrx_pkg::DATA_W-1:0]};
         end
         file_req_q.wr_en <= active_q && at_q3 && is_rot && dest_file;
         if (active_q && at_q3 && is_rot) begin
            file_req_q.wr_data <= rot_dout;
            rot_res_q <= rot_dout;
            rot_c_q <= rot_cout;
            rot_n_q <= rot_neg;
            rot_z_q <= rot_zero;
         end
      end
   end

   assign stack_pop = pop_q;
   assign file_req = file_req_q;
   assign core = core_q;
   assign pc = pc_q;
   assign high_prio_global_int_enable = hi_en_q;
   assign low_prio_global_int_enable = lo_en_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_ret_commit;
      exec_q4 && is_ret;
   endsequence

   sequence s_idle_cycle;
      (!stack_pop && !file_req.wr_en && !instr_ready)[*4] ##1 instr_ready;
   endsequence

   a_pop_in_q4:
      assert property (stack_pop |-> at_q4 && active_q && is_ret)
      else $error("stack pop outside Q4 of a return");
   a_ret_pc_load:
      assert property (s_ret_commit |=> pc == $past(stack_top))
      else $error("pc not loaded from stack top on return");
   a_ret_gie_set:
      assert property (exec_q4 && is_ret_int |=> (int_level_high ?
         high_prio_global_int_enable : low_prio_global_int_enable) [*1] ##3 1)
      else $error("global enable not set by interrupt return");
   a_fast_restore:
      assert property (exec_q4 && fast |=> core == $past(shadow))
      else $error("shadow copies not restored");
   a_slow_keep_regs:
      assert property (exec_q4 && (is_ret_int || is_ret_sub) && !fast |=> $stable(core))
      else $error("registers changed on plain return");
   a_ret_lit_w:
      assert property (exec_q4 && is_ret_lit |=> core.w == $past(instr_q[7:0]))
      else $error("literal not loaded into working register");
   a_ret_idle_cycle:
      assert property (s_ret_commit |=> s_idle_cycle)
      else $error("second return cycle not idle");
   a_rot_value:
      assert property (active_q && at_q3 && is_rot |=>
         rot_res_q == {$past(file_rd_data[6:0]), $past(core.status[rrx_pkg::ST_C])}
         && rot_c_q == $past(file_rd_data[7]))
      else $error("rotate result or carry wrong");
   a_rot_dest:
      assert property (active_q && at_q3 && is_rot |=> file_req.wr_en == $past(dest_file)
         ##1 (dest_file || core.w == $past(rot_res_q)))
      else $error("rotate result sent to wrong destination");
   a_rot_flags:
      assert property (exec_q4 && is_rot |=>
         core.status[rrx_pkg::ST_N] == $past(rot_res_q[7])
         && core.status[rrx_pkg::ST_Z] == ($past(rot_res_q) == 8'h00))
      else $error("rotate flags wrong");
   a_bank_select:
      assert property (active_q && at_q2 && is_rot && !instr_q[rrx_pkg::FLD_ACCESS] |=>
         file_req.addr[11:8] == ($past(instr_q[7]) ? 4'hF : 4'h0))
      else $error("access bank not used");
endmodule
`default_nettype wire

/* File: design/rrx_pkg.sv */
/*
 rrx_pkg: constants, state enumerations and carrier structs for the
 return and rotate execution block.
 Assumes a core running four Q phases per instruction cycle on one clock.
*/
package rrx_pkg;
   localparam int PC_W_DEF = 21;
   localparam int DATA_W = 8;
   localparam int BANK_W = 4;
   localparam int INSTR_W = 16;

   // opcode patterns, compared against the upper bits of the instruction word
   localparam logic [14:0] OP_RET_INT_HI = 15'h0008;
   localparam logic [14:0] OP_RET_SUB_HI = 15'h0009;
   localparam logic [7:0] OP_RET_LIT = 8'h0C;
   localparam logic [5:0] OP_ROT_LC = 6'h0D;

   // operand field positions
   localparam int FLD_DEST = 9;
   localparam int FLD_ACCESS = 8;
   localparam int FLD_FAST = 0;
   localparam int FLD_SPLIT = 7;

   // status bit positions
   localparam int ST_C = 0;
   localparam int ST_Z = 2;
   localparam int ST_N = 4;

   // access bank halves
   localparam logic [BANK_W-1:0] ACC_BANK_LO = 4'h0;
   localparam logic [BANK_W-1:0] ACC_BANK_HI = 4'hF;

   // values after reset
   localparam logic [DATA_W-1:0] RST_W = 8'h00;
   localparam logic [DATA_W-1:0] RST_STATUS = 8'h00;
   localparam logic [BANK_W-1:0] RST_BANK = 4'h0;
   localparam logic RST_INT_EN = 1'b0;

   typedef enum {QP_1, QP_2, QP_3, QP_4} rrx_qphase_t;
   typedef enum {ST_EXEC, ST_IDLE} rrx_state_t;

   typedef struct packed {
      logic [DATA_W-1:0] w;
      logic [DATA_W-1:0] status;
      logic [BANK_W-1:0] bank;
   } rrx_core_t;

   typedef struct packed {
      logic [BANK_W+DATA_W-1:0] addr;
      logic wr_en;
      logic [DATA_W-1:0] wr_data;
   } rrx_file_req_t;
endpackage

/* File: design/rrx_rotate.sv */
/*
 rrx_rotate: combinational rotate-left-through-carry with result flags.
 Assumes the caller registers its outputs.
*/
`timescale 1ns/10ps
`default_nettype none
module rrx_rotate (
   input wire logic [rrx_pkg::DATA_W-1:0] din,
   input wire logic cin,
   output logic [rrx_pkg::DATA_W-1:0] dout,
   output logic cout,
   output logic neg,
   output logic zero
);
   assign dout = {din[rrx_pkg::DATA_W-2:0], cin};
   assign cout = din[rrx_pkg::DATA_W-1];
   assign neg = dout[rrx_pkg::DATA_W-1];
   assign zero = (dout == '0);
endmodule
`default_nettype wire

/* File: bench/rrx_exec_tb_top.sv */
/*
 rrx_exec_tb_top: self-checking bench for the return and rotate block.
 Assumes rrx_pkg and rrx_exec are compiled first; the bench plays fetch,
 return stack, shadow registers and register file itself.
*/
`timescale 1ns/10ps
`default_nettype none
module rrx_exec_tb_top;
   logic clk, reset, instr_valid, int_level_high, int_taken, instr_ready, stack_pop;
   logic en_hi, en_lo;
   logic [15:0] instr;
   logic [20:0] stack_top, pc, pc_exp;
   logic [7:0] file_rd_data;
   rrx_pkg::rrx_core_t shadow, core, ex;
   rrx_pkg::rrx_file_req_t file_req;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;

   rrx_exec i_rrx_exec (.clk(clk), .reset(reset), .instr_valid(instr_valid),
      .instr(instr), .instr_ready(instr_ready), .stack_top(stack_top),
      .stack_pop(stack_pop), .int_level_high(int_level_high), .int_taken(int_taken),
      .shadow(shadow), .file_rd_data(file_rd_data), .file_req(file_req), .core(core),
      .pc(pc), .high_prio_global_int_enable(en_hi), .low_prio_global_int_enable(en_lo));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // about 70 cycles expected; generous ceiling
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         miscompares++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %0h seen %0h", n, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   // entered at a falling edge; leaves one falling edge after the take edge
   task automatic issue(input logic [15:0] w);
      int i;
      instr = w;
      instr_valid = 1'b1;
      i = 0;
      while (instr_ready !== 1'b1 && i < 20) begin
         step(1);
         i++;
      end
      chk("instr_ready", instr_ready, 1'b1);
      @(posedge clk);
      @(negedge clk);
      instr_valid = 1'b0;
   endtask

   task automatic ret(input logic [15:0] w, input logic [20:0] top);
      stack_top = top;
      pc_exp = top;
      issue(w);
      chk("stack_pop_q2", stack_pop, 1'b0);
      step(2);
      chk("stack_pop_q4", stack_pop, 1'b1);
      step(1);
      chk("pc", pc, top);
      chk("stack_pop_end", stack_pop, 1'b0);
      chk("ready_idle", instr_ready, 1'b0);
      step(3);
      chk("ready_idle_end", instr_ready, 1'b0);
      step(1);
      chk("ready_back", instr_ready, 1'b1);
      chk("core", core, ex);
   endtask

   task automatic t_reset();
      chk("pc_rst", pc, 21'h000000);
      chk("core_rst", core, 20'h00000);
      chk("file_rst", file_req, 21'h000000);
      chk("en_rst", {en_hi, en_lo}, 2'h0);
      chk("pop_rst", stack_pop, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_int();
      shadow = {8'hA5, 8'h01, 4'h3};
      int_level_high = 1'b1;
      ex = shadow;
      ret(16'h0011, 21'h01ABCD);
      chk("en_high", {en_hi, en_lo}, 2'h2);
      // entry pulse kept clear of any return edge
      int_taken = 1'b1;
      step(1);
      int_taken = 1'b0;
      step(1);
      chk("en_clear", {en_hi, en_lo}, 2'h0);
      shadow = {8'h5A, 8'hF0, 4'hC};
      int_level_high = 1'b0;
      ret(16'h0010, 21'h000042);
      chk("en_low", {en_hi, en_lo}, 2'h1);
      int_taken = 1'b1;
      step(1);
      int_taken = 1'b0;
      step(1);
      chk("en_clear_lo", {en_hi, en_lo}, 2'h0);
      $display("test interrupt return done");
   endtask

   // entry pulse on the very edge of the return's Q4: the return must win
   task automatic t_race();
      int_level_high = 1'b1;
      stack_top = 21'h000777;
      pc_exp = 21'h000777;
      issue(16'h0010);
      step(2);
      int_taken = 1'b1;
      step(1);
      int_taken = 1'b0;
      chk("en_race", {en_hi, en_lo}, 2'h2);
      chk("pc_race", pc, 21'h000777);
      step(4);
      chk("core_race", core, ex);
      $display("test enable race done");
   endtask

   task automatic t_sub();
      shadow = {8'h77, 8'h00, 4'h5};
      ret(16'h0012, 21'h00F00F);
      ex = shadow;
      ret(16'h0013, 21'h015555);
      $display("test subroutine return done");
   endtask

   task automatic t_lit();
      ex.w = 8'hC3;
      ret(16'h0CC3, 21'h002468);
      $display("test literal return done");
   endtask

   task automatic rot(input logic [15:0] w, input logic [7:0] rd, input logic [11:0] addr);
      logic [7:0] res;
      res = {rd[6:0], ex.status[rrx_pkg::ST_C]};
      file_rd_data = rd;
      issue(w);
      step(1);
      chk("file_addr", file_req.addr, addr);
      step(1);
      chk("wr_en", file_req.wr_en, w[9]);
      if (w[9]) chk("wr_data", file_req.wr_data, res);
      ex.status[rrx_pkg::ST_C] = rd[7];
      ex.status[rrx_pkg::ST_N] = res[7];
      ex.status[rrx_pkg::ST_Z] = (res == 8'h00);
      if (!w[9]) ex.w = res;
      step(1);
      chk("core_rot", core, ex);
      chk("wr_en_end", file_req.wr_en, 1'b0);
      chk("pc_keep", pc, pc_exp);
      chk("ready_next", instr_ready, 1'b1);
   endtask

   task automatic t_rot();
      // back to back: access upper half, banked, then zero result
      rot(16'h3481, 8'hE6, 12'hF81);
      rot(16'h3722, 8'h40, 12'h522);
      rot(16'h3610, 8'h80, 12'h010);
      $display("test rotate done");
   endtask

   initial begin
      reset = 1'b1;
      instr_valid = 1'b0;
      instr = 16'h0000;
      stack_top = 21'h000000;
      pc_exp = 21'h000000;
      int_level_high = 1'b0;
      int_taken = 1'b0;
      shadow = 20'h00000;
      file_rd_data = 8'h00;
      ex = 20'h00000;
      step(3);
      t_reset();
      reset = 1'b0;
      t_int();
      t_race();
      t_sub();
      t_lit();
      t_rot();
      test_done();
   end
endmodule
`default_nettype wire
